// ### verilog/cmi_pkg.sv
// Constants and types shared by the message-interface command logic
package cmi_pkg;

  // Register byte offsets
  localparam logic [7:0] CMI_OFS_CMD_REQ = 8'h20;
  localparam logic [7:0] CMI_OFS_CMD_MASK = 8'h24;
  localparam logic [7:0] CMI_OFS_MSG_CTL = 8'h38;
  localparam logic [7:0] CMI_OFS_LOW_LO = 8'h3c;
  localparam logic [7:0] CMI_OFS_LOW_HI = 8'h40;
  localparam logic [7:0] CMI_OFS_HIGH_LO = 8'h44;
  localparam logic [7:0] CMI_OFS_HIGH_HI = 8'h48;

  // Command mask field positions
  localparam int CMI_MSK_DIR = 7;
  localparam int CMI_MSK_CTRL = 4;
  localparam int CMI_MSK_CLRPEND = 3;
  localparam int CMI_MSK_FRESH_TX = 2;
  localparam int CMI_MSK_LOW = 1;
  localparam int CMI_MSK_HIGH = 0;
  localparam int CMI_MSK_W = 8;

  // Message control field positions
  localparam int CMI_CTL_FRESH = 15;
  localparam int CMI_CTL_PEND = 13;
  localparam int CMI_CTL_TXRQ = 8;
  localparam int CMI_CTL_W = 16;

  // Command request fields
  localparam int CMI_CRQ_BUSY = 15;
  localparam int CMI_NUM_W = 6;
  localparam int CMI_IDX_W = 5;
  localparam int CMI_OBJS = 32;
  localparam logic [CMI_NUM_W-1:0] CMI_NUM_RESET = 6'h01;
  localparam logic [CMI_IDX_W-1:0] CMI_IDX_LAST = 5'h1f;
  localparam logic [CMI_IDX_W-1:0] CMI_IDX_ONE = 5'h01;

  // Transfer timing in module clock periods, legal window 3 to 6
  localparam int CMI_XFER_MIN = 3;
  localparam int CMI_XFER_MAX = 6;
  localparam int CMI_XFER_CYC = 4;
  localparam logic [2:0] CMI_WAIT_LAST = 3'(CMI_XFER_CYC - 2);

  typedef enum logic [1:0] {
    CMI_IDLE,
    CMI_WAIT,
    CMI_APPLY
  } cmi_state_t;

endpackage : cmi_pkg

// ### verilog/cmi_obj_index.sv
// Maps a written object number onto a message RAM row
`timescale 1ns/1ps
module cmi_obj_index
  import cmi_pkg::*;
(
  // Object number as held in the command request register
  input wire logic [CMI_NUM_W-1:0] object_number,
  // Row of the message RAM
  output logic [CMI_IDX_W-1:0] obj_idx
);

  // Zero means object 32; values above 32 wrap onto 1 to 31
  always_comb begin
    if (object_number[CMI_IDX_W-1:0] == '0) begin
      obj_idx = CMI_IDX_LAST;
    end else begin
      obj_idx = object_number[CMI_IDX_W-1:0] - CMI_IDX_ONE;
    end
  end

endmodule : cmi_obj_index

// ### verilog/cmi_obj_ram.sv
// Message object store: control word and eight payload bytes per object
`timescale 1ns/1ps
module cmi_obj_ram
  import cmi_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Read port, combinational
  input wire logic [CMI_IDX_W-1:0] idx,
  output logic [CMI_CTL_W-1:0] rd_ctrl,
  output logic [63:0] rd_data,
  // Write port from the interface transfer
  input wire logic wr_ctrl_en,
  input wire logic [CMI_CTL_W-1:0] wr_ctrl,
  input wire logic wr_low_en,
  input wire logic wr_high_en,
  input wire logic [63:0] wr_data,
  // Flag events from the protocol engine
  input wire logic evt_valid,
  input wire logic [CMI_IDX_W-1:0] evt_idx,
  input wire logic evt_pending,
  input wire logic evt_fresh
);

  logic [CMI_CTL_W-1:0] ctrl_mem [CMI_OBJS];
  logic [63:0] data_mem [CMI_OBJS];

  assign rd_ctrl = ctrl_mem[idx];
  assign rd_data = data_mem[idx];

  // Payload has no reset; software loads it before use
  always_ff @(posedge clock) begin
    if (wr_low_en) begin
      data_mem[idx][31:0] <= wr_data[31:0];
    end
    if (wr_high_en) begin
      data_mem[idx][63:32] <= wr_data[63:32];
    end
  end

  // Engine events set flags after the transfer write, so a set beats a clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < CMI_OBJS; i++) begin
        ctrl_mem[i] <= '0;
      end
    end else begin
      if (wr_ctrl_en) begin
        ctrl_mem[idx] <= wr_ctrl;
      end
      if (evt_valid && evt_pending) begin
        ctrl_mem[evt_idx][CMI_CTL_PEND] <= 1'b1;
      end
      if (evt_valid && evt_fresh) begin
        ctrl_mem[evt_idx][CMI_CTL_FRESH] <= 1'b1;
      end
    end
  end

endmodule : cmi_obj_ram

// ### verilog/cmi_cmd_sel.sv
// Command request, command mask and interface buffers of one message interface
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - Control select moves control bits between interface register and object; else unchanged.
// - Writing with clear-pending select clears the object's interrupt pending flag.
// - Reading without clear-pending copies the object's pending flag to the interface.
// - Reading with clear-pending clears the object flag, copying the pre-clear value.
// - Writing with transmit select starts transmission; interface request bit ignored.
// - Reading without fresh select copies the object's fresh-data flag.
// - Reading with fresh select clears the object flag, copying the pre-clear value.
// - Low payload select moves bytes 0-3; direction set copies object to interface.
// - High payload select moves bytes 4-7; direction set copies object to interface.
// - Writing an object number starts a transfer; busy holds 3 to 6 cycles.
// - Object numbers 1 to 32 select objects; zero means object 32.
module cmi_cmd_sel
  import cmi_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Protocol engine flag events
  input wire logic evt_valid,
  input wire logic [CMI_IDX_W-1:0] evt_idx,
  input wire logic evt_pending,
  input wire logic evt_fresh,
  // Transmit start towards the protocol engine
  output logic tx_start,
  output logic [CMI_IDX_W-1:0] tx_idx,
  // Transfer status
  output logic busy
);

  typedef struct packed {
    cmi_state_t st;
    logic [2:0] cnt;
    logic busy;
    logic [CMI_NUM_W-1:0] object_number;
    logic [CMI_MSK_W-1:0] if_command_mask;
    logic [CMI_CTL_W-1:0] if_message_control_reg;
    logic [15:0] if_low_payload_reg_lo;
    logic [15:0] if_low_payload_reg_hi;
    logic [15:0] if_high_payload_reg_lo;
    logic [15:0] if_high_payload_reg_hi;
    logic tx_start;
    logic [CMI_IDX_W-1:0] tx_idx;
    logic [31:0] rdata;
  } cmi_regs_t;

  cmi_regs_t r_q;
  cmi_regs_t r_d;
  logic [CMI_IDX_W-1:0] obj_idx;
  logic [CMI_CTL_W-1:0] ram_ctrl;
  logic [63:0] ram_data;
  logic [CMI_CTL_W-1:0] new_ctrl;
  logic apply;
  logic dir_wr;
  logic sel_ctrl;
  logic sel_clr;
  logic sel_ftx;
  logic sel_low;
  logic sel_high;
  logic crq_write;

  ////////////////////////////////////////////////////////////////////////////
  // Object row and message store

  cmi_obj_index u_index (
    .object_number(r_q.object_number),
    .obj_idx(obj_idx)
  );

  assign apply = (r_q.st == CMI_APPLY);
  assign dir_wr = r_q.if_command_mask[CMI_MSK_DIR];
  assign sel_ctrl = r_q.if_command_mask[CMI_MSK_CTRL];
  assign sel_clr = r_q.if_command_mask[CMI_MSK_CLRPEND];
  assign sel_ftx = r_q.if_command_mask[CMI_MSK_FRESH_TX];
  assign sel_low = r_q.if_command_mask[CMI_MSK_LOW];
  assign sel_high = r_q.if_command_mask[CMI_MSK_HIGH];
  assign crq_write = reg_write && (reg_addr == CMI_OFS_CMD_REQ);

  // Control word written back to the object at the end of a transfer
  always_comb begin
    new_ctrl = ram_ctrl;
    if (dir_wr) begin
      if (sel_ctrl) begin
        new_ctrl = r_q.if_message_control_reg;
      end
      if (sel_ftx) begin
        new_ctrl[CMI_CTL_TXRQ] = 1'b1;
      end
      if (sel_clr) begin
        new_ctrl[CMI_CTL_PEND] = 1'b0;
      end
    end else begin
      if (sel_clr) begin
        new_ctrl[CMI_CTL_PEND] = 1'b0;
      end
      if (sel_ftx) begin
        new_ctrl[CMI_CTL_FRESH] = 1'b0;
      end
    end
  end

  // Payload: direction set fills the buffers, direction clear feeds the object; the control word is written back in both
  cmi_obj_ram u_ram (
    .clock(clock),
    .sys_rst(sys_rst),
    .idx(obj_idx),
    .rd_ctrl(ram_ctrl),
    .rd_data(ram_data),
    .wr_ctrl_en(apply),
    .wr_ctrl(new_ctrl),
    .wr_low_en(apply && !dir_wr && sel_low),
    .wr_high_en(apply && !dir_wr && sel_high),
    .wr_data({r_q.if_high_payload_reg_hi, r_q.if_high_payload_reg_lo,
              r_q.if_low_payload_reg_hi, r_q.if_low_payload_reg_lo}),
    .evt_valid(evt_valid),
    .evt_idx(evt_idx),
    .evt_pending(evt_pending),
    .evt_fresh(evt_fresh)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file and transfer sequencer

  always_comb begin
    r_d = r_q;
    r_d.tx_start = 1'b0;
    r_d.rdata = '0;
    if (reg_write) begin
      unique case (reg_addr)
        CMI_OFS_CMD_MASK: r_d.if_command_mask = reg_wdata[CMI_MSK_W-1:0];
        CMI_OFS_MSG_CTL: r_d.if_message_control_reg = reg_wdata[CMI_CTL_W-1:0];
        CMI_OFS_LOW_LO: r_d.if_low_payload_reg_lo = reg_wdata[15:0];
        CMI_OFS_LOW_HI: r_d.if_low_payload_reg_hi = reg_wdata[15:0];
        CMI_OFS_HIGH_LO: r_d.if_high_payload_reg_lo = reg_wdata[15:0];
        CMI_OFS_HIGH_HI: r_d.if_high_payload_reg_hi = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        CMI_OFS_CMD_REQ: r_d.rdata = {16'h0000, r_q.busy, 9'h000, r_q.object_number};
        CMI_OFS_CMD_MASK: r_d.rdata = {24'h000000, r_q.if_command_mask};
        CMI_OFS_MSG_CTL: r_d.rdata = {16'h0000, r_q.if_message_control_reg};
        CMI_OFS_LOW_LO: r_d.rdata = {16'h0000, r_q.if_low_payload_reg_lo};
        CMI_OFS_LOW_HI: r_d.rdata = {16'h0000, r_q.if_low_payload_reg_hi};
        CMI_OFS_HIGH_LO: r_d.rdata = {16'h0000, r_q.if_high_payload_reg_lo};
        CMI_OFS_HIGH_HI: r_d.rdata = {16'h0000, r_q.if_high_payload_reg_hi};
        default: r_d.rdata = '0;
      endcase
    end
    unique case (r_q.st)
      CMI_IDLE: begin
        if (crq_write) begin
          r_d.object_number = reg_wdata[CMI_NUM_W-1:0];
          r_d.busy = 1'b1;
          r_d.cnt = '0;
          r_d.st = CMI_WAIT;
        end
      end
      CMI_WAIT: begin
        // Waits model the store arbitration slot
        r_d.cnt = r_q.cnt + 3'h1;
        if (r_q.cnt == CMI_WAIT_LAST) begin
          r_d.st = CMI_APPLY;
        end
      end
      CMI_APPLY: begin
        r_d.busy = 1'b0;
        r_d.st = CMI_IDLE;
        if (dir_wr) begin
          if (sel_ftx) begin
            r_d.tx_start = 1'b1;
            r_d.tx_idx = obj_idx;
          end
          if (sel_low) begin
            r_d.if_low_payload_reg_lo = ram_data[15:0];
            r_d.if_low_payload_reg_hi = ram_data[31:16];
          end
          if (sel_high) begin
            r_d.if_high_payload_reg_lo = ram_data[47:32];
            r_d.if_high_payload_reg_hi = ram_data[63:48];
          end
        end else begin
          if (sel_ctrl) begin
            r_d.if_message_control_reg = ram_ctrl;
          end
          // Flags always reflect the object before any clear
          r_d.if_message_control_reg[CMI_CTL_PEND] = ram_ctrl[CMI_CTL_PEND];
          r_d.if_message_control_reg[CMI_CTL_FRESH] = ram_ctrl[CMI_CTL_FRESH];
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '{st: CMI_IDLE, object_number: CMI_NUM_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign tx_start = r_q.tx_start;
  assign tx_idx = r_q.tx_idx;
  assign busy = r_q.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Delay bounds kept as int constants of this file
  localparam int CHK_XFER_MIN = CMI_XFER_MIN;
  localparam int CHK_XFER_MAX = CMI_XFER_MAX;

  sequence s_start;
    !r_q.busy && crq_write;
  endsequence

  sequence s_busy_window;
    r_q.busy [*4] ##1 !r_q.busy;
  endsequence

  property p_busy_len;
    s_start |=> s_busy_window;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  property p_busy_bound;
    $rose(r_q.busy) |-> ##[CHK_XFER_MIN:CHK_XFER_MAX] !r_q.busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy outside window");

  property p_obj_zero;
    (r_q.object_number[CMI_IDX_W-1:0] == '0) |-> (obj_idx == CMI_IDX_LAST);
  endproperty
  a_obj_zero: assert property (p_obj_zero) else $error("object zero not mapped to 32");

  property p_tx_start;
    apply |=> (tx_start == $past(dir_wr && sel_ftx));
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit start mismatch");

  property p_pend_copy;
    apply && !dir_wr |=> r_q.if_message_control_reg[CMI_CTL_PEND] == $past(ram_ctrl[CMI_CTL_PEND]);
  endproperty
  a_pend_copy: assert property (p_pend_copy) else $error("pending flag not copied");

  property p_fresh_copy;
    apply && !dir_wr |=> r_q.if_message_control_reg[CMI_CTL_FRESH] == $past(ram_ctrl[CMI_CTL_FRESH]);
  endproperty
  a_fresh_copy: assert property (p_fresh_copy) else $error("fresh flag not copied");

  property p_pend_clear;
    apply && sel_clr && !(evt_valid && evt_pending && evt_idx == obj_idx) |=> !ram_ctrl[CMI_CTL_PEND];
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending flag not cleared");

  property p_fresh_clear;
    apply && !dir_wr && sel_ftx && !(evt_valid && evt_fresh && evt_idx == obj_idx)
      |=> !ram_ctrl[CMI_CTL_FRESH];
  endproperty
  a_fresh_clear: assert property (p_fresh_clear) else $error("fresh flag not cleared");

  property p_low_in;
    apply && dir_wr && sel_low |=> r_q.if_low_payload_reg_hi == $past(ram_data[31:16]);
  endproperty
  a_low_in: assert property (p_low_in) else $error("low payload not loaded");

  property p_high_out;
    apply && !dir_wr && sel_high |=> ram_data[63:48] == $past(r_q.if_high_payload_reg_hi);
  endproperty
  a_high_out: assert property (p_high_out) else $error("high payload not stored");

  property p_ctrl_keep;
    apply && !dir_wr && !sel_ctrl
      |=> r_q.if_message_control_reg[CMI_CTL_TXRQ] == $past(r_q.if_message_control_reg[CMI_CTL_TXRQ]);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control bits changed");

  property p_low_out;
    apply && !dir_wr && sel_low |=> ram_data[15:0] == $past(r_q.if_low_payload_reg_lo);
  endproperty
  a_low_out: assert property (p_low_out) else $error("low payload not stored");

  property p_high_in;
    apply && dir_wr && sel_high |=> r_q.if_high_payload_reg_lo == $past(ram_data[47:32]);
  endproperty
  a_high_in: assert property (p_high_in) else $error("high payload not loaded");

  property p_tx_req;
    apply && dir_wr && sel_ftx |=> ram_ctrl[CMI_CTL_TXRQ];
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("object transmit request not set");

endmodule : cmi_cmd_sel

// ### sim/cmi_engine_model.sv
// Protocol engine stand-in: raises flag events and records transmit starts
`timescale 1ns/1ps
module cmi_engine_model
  import cmi_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Flag events towards the interface
  output logic evt_valid,
  output logic [CMI_IDX_W-1:0] evt_idx,
  output logic evt_pending,
  output logic evt_fresh,
  // Transmit starts from the interface
  input wire logic tx_start,
  input wire logic [CMI_IDX_W-1:0] tx_idx
);
  int tx_count;
  logic [CMI_IDX_W-1:0] tx_last;

  initial begin
    evt_valid = 1'b0;
    evt_idx = 5'h15;
    evt_pending = 1'b1;
    evt_fresh = 1'b0;
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_count <= 0;
      tx_last <= 5'h00;
    end else if (tx_start === 1'b1) begin
      tx_count <= tx_count + 1;
      tx_last <= tx_idx;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outside an event the qualifiers flip, so a design that ignores valid is caught
  task automatic raise(input logic [CMI_IDX_W-1:0] idx, input logic pend, input logic fresh);
    @(posedge clock);
    evt_valid <= 1'b1;
    evt_idx <= idx;
    evt_pending <= pend;
    evt_fresh <= fresh;
    @(posedge clock);
    evt_valid <= 1'b0;
    evt_idx <= ~idx;
    evt_pending <= ~pend;
    evt_fresh <= ~fresh;
  endtask : raise
endmodule : cmi_engine_model

// ### sim/cmi_cmd_sel_test.sv
// Self-checking bench of the message-interface command logic
`timescale 1ns/1ps
module cmi_cmd_sel_test
  import cmi_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic evt_valid;
  logic [CMI_IDX_W-1:0] evt_idx;
  logic evt_pending;
  logic evt_fresh;
  logic tx_start;
  logic [CMI_IDX_W-1:0] tx_idx;
  logic busy;
  int n_errors = 0;
  int checks = 0;

  always #5 clock = ~clock;

  cmi_cmd_sel dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .evt_valid(evt_valid),
    .evt_idx(evt_idx), .evt_pending(evt_pending), .evt_fresh(evt_fresh), .tx_start(tx_start),
    .tx_idx(tx_idx), .busy(busy));

  cmi_engine_model eng (.clock(clock), .sys_rst(sys_rst), .evt_valid(evt_valid), .evt_idx(evt_idx),
    .evt_pending(evt_pending), .evt_fresh(evt_fresh), .tx_start(tx_start), .tx_idx(tx_idx));

  ////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_len(input int n);
    checks++;
    if (n < CMI_XFER_MIN || n > CMI_XFER_MAX) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, n, CMI_XFER_CYC);
    end
  endtask : chk_len

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk

  // Busy length counted from the edge that took the request
  task automatic wait_idle(output int n);
    n = 0;
    #1;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 20) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, busy, 1'b0);
      finish_test();
    end
  endtask : wait_idle

  // Mask is set only while idle, and the next request waits for busy to drop
  task automatic xfer(input logic [7:0] mask, input logic [5:0] num);
    int n;
    wr(CMI_OFS_CMD_MASK, {24'h0, mask});
    wr(CMI_OFS_CMD_REQ, {26'h0, num});
    wait_idle(n);
    chk_len(n);
  endtask : xfer

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({31'h0, busy}, 32'h0);
    rd_chk(CMI_OFS_CMD_REQ, 32'h1);
    rd_chk(CMI_OFS_CMD_MASK, 32'h0);
    wr(CMI_OFS_CMD_MASK, 32'hffff_ffff);
    rd_chk(CMI_OFS_CMD_MASK, 32'h0000_00ff);
    wr(8'h04, 32'h1234_5678);
    rd_chk(8'h04, 32'h0);
    $display("Reset and map test done");
  endtask : t_reset

  task automatic t_flags_read;
    eng.raise(5'h06, 1'b1, 1'b1);
    xfer(8'h00, 6'h07);
    rd_chk(CMI_OFS_MSG_CTL, 32'h0000_a000);
    xfer(8'h0c, 6'h07);
    rd_chk(CMI_OFS_MSG_CTL, 32'h0000_a000);
    xfer(8'h00, 6'h07);
    rd_chk(CMI_OFS_MSG_CTL, 32'h0000_0000);
    $display("Flag read test done");
  endtask : t_flags_read

  task automatic t_pend_write;
    eng.raise(5'h08, 1'b1, 1'b0);
    xfer(8'h80, 6'h09);
    xfer(8'h00, 6'h09);
    rd_chk(CMI_OFS_MSG_CTL, 32'h0000_2000);
    xfer(8'h88, 6'h09);
    xfer(8'h00, 6'h09);
    rd_chk(CMI_OFS_MSG_CTL, 32'h0000_0000);
    $display("Pending clear test done");
  endtask : t_pend_write

  task automatic t_control;
    wr(CMI_OFS_MSG_CTL, 32'h0000_0055);
    xfer(8'h90, 6'h03);
    wr(CMI_OFS_MSG_CTL, 32'h0);
    xfer(8'h10, 6'h03);
    rd_chk(CMI_OFS_MSG_CTL, 32'h0000_0055);
    wr(CMI_OFS_MSG_CTL, 32'h0000_0011);
    xfer(8'h00, 6'h03);
    rd_chk(CMI_OFS_MSG_CTL, 32'h0000_0011);
    $display("Control test done");
  endtask : t_control

  task automatic t_payload;
    logic [7:0] a [4];
    a = '{CMI_OFS_LOW_LO, CMI_OFS_LOW_HI, CMI_OFS_HIGH_LO, CMI_OFS_HIGH_HI};
    for (int i = 0; i < 4; i++) begin
      wr(a[i], 32'h1111 * (i + 1));
    end
    xfer(8'h03, 6'h05);
    for (int i = 0; i < 4; i++) begin
      wr(a[i], 32'h0);
    end
    xfer(8'h82, 6'h05);
    rd_chk(a[0], 32'h1111);
    rd_chk(a[1], 32'h2222);
    rd_chk(a[2], 32'h0);
    xfer(8'h81, 6'h05);
    rd_chk(a[2], 32'h3333);
    rd_chk(a[3], 32'h4444);
    rd_chk(a[1], 32'h2222);
    $display("Payload test done");
  endtask : t_payload

  task automatic t_transmit;
    int c;
    int n;
    c = eng.tx_count;
    wr(CMI_OFS_MSG_CTL, 32'h0);
    xfer(8'h84, 6'h00);
    rd_chk(CMI_OFS_CMD_REQ, 32'h0);
    chk(eng.tx_count, c + 1);
    chk({27'h0, eng.tx_last}, {27'h0, CMI_IDX_LAST});
    xfer(8'h80, 6'h02);
    rd_chk(CMI_OFS_CMD_REQ, 32'h2);
    chk(eng.tx_count, c + 1);
    wr(CMI_OFS_CMD_REQ, 32'h0000_0003);
    wr(CMI_OFS_CMD_REQ, 32'h0000_0004);
    wait_idle(n);
    rd_chk(CMI_OFS_CMD_REQ, 32'h3);
    $display("Transmit test done");
  endtask : t_transmit

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_flags_read();
    t_pend_write();
    t_control();
    t_payload();
    t_transmit();
    finish_test();
  end
endmodule : cmi_cmd_sel_test
